// [shared/status_pkg.sv]
// constants for the status reporting block
package status_pkg;
    // -------------------------------------------------------------
    // status byte bit positions
    // -------------------------------------------------------------
    localparam int STB_CHANNEL_BIT  = 2;
    localparam int STB_QUEST_BIT    = 3;
    localparam int STB_MSG_AVAIL    = 4;
    localparam int STB_EVENT_SUM    = 5;
    localparam int STB_REQ_MASTER   = 6;

    // -------------------------------------------------------------
    // standard event bit positions
    // -------------------------------------------------------------
    localparam int SEV_OP_COMPLETE  = 0;
    localparam int SEV_QUERY_ERR    = 2;
    localparam int SEV_DEVICE_ERR   = 3;
    localparam int SEV_EXEC_ERR     = 4;
    localparam int SEV_COMMAND_ERR  = 5;

    // -------------------------------------------------------------
    // reset values and queue defaults
    // -------------------------------------------------------------
    localparam logic [7:0] SEV_RESET    = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam int QUEUE_WIDTH_DEF      = 8;
    localparam int QUEUE_DEPTH_DEF      = 16;
endpackage : status_pkg

// [logic/resp_queue_mem.sv]
// response queue storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module resp_queue_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock
    input  wire logic             i_clk,
    // write side
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    // read side
    input  wire logic             i_re,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // storage has no reset; read data is a plain register
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : resp_queue_mem
`default_nettype wire

// [logic/status_reporting_summary.sv]
// status byte, standard event register and response queue
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - responses kept in order until read
// - message available while queue not empty
// - programming errors latch standard event bits
// - event register read returns then clears
// - masked event bits ORed to bit 5
// - operation complete only after completion command
// - empty read or lost data: query error
// - memory loss or selftest fail: device error
// - bad parameter or condition: execution error
// - syntax error or mid-message trigger: command error
// - bit 2 shows channel summary
// - bit 3 shows questionable summary
// - serial poll returns then clears request
// - stb query returns master summary, no change
// - master summary set on any enabled service reason
// - clear command clears the event register and the service request
// - service request only for enabled bits
// - event bits latch on rising condition
module status_reporting_summary
    import status_pkg::*;
#(
    parameter int QWIDTH = QUEUE_WIDTH_DEF,
    parameter int QDEPTH = QUEUE_DEPTH_DEF
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // response producer
    input  wire logic              i_resp_valid,
    input  wire logic [QWIDTH-1:0] i_resp_data,
    input  wire logic              i_resp_lost,
    // host read of the response queue
    input  wire logic              i_resp_read,
    output logic                   o_resp_valid,
    output logic      [QWIDTH-1:0] o_resp_data,
    // error and event conditions (levels)
    input  wire logic              i_complete_cmd,
    input  wire logic              i_ops_pending,
    input  wire logic              i_memory_lost,
    input  wire logic              i_selftest_fail,
    input  wire logic              i_param_error,
    input  wire logic              i_exec_blocked,
    input  wire logic              i_syntax_error,
    input  wire logic              i_trigger_in_msg,
    // summaries from other register groups
    input  wire logic              i_channel_summary,
    input  wire logic              i_questionable_summary,
    // host register commands
    input  wire logic              i_event_enable_we,
    input  wire logic [7:0]        i_event_enable_data,
    input  wire logic              i_srq_enable_we,
    input  wire logic [7:0]        i_srq_enable_data,
    input  wire logic              i_event_read,
    input  wire logic              i_serial_poll,
    input  wire logic              i_stb_query,
    input  wire logic              i_clear_status,
    // register answers
    output logic      [7:0]        o_event_data,
    output logic                   o_event_data_valid,
    output logic      [7:0]        o_stb_data,
    output logic                   o_stb_data_valid,
    output logic      [7:0]        o_event_enable,
    output logic      [7:0]        o_srq_enable,
    output logic                   o_service_request
);
    // -------------------------------------------------------------
    // parameter checks
    // -------------------------------------------------------------
    localparam int AW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
    // refuse sizes that the queue logic cannot serve
    // the wrap-bit compare only works for a power-of-two depth
    if (QDEPTH < 2 || (1 << AW) != QDEPTH || QWIDTH < 1) begin : g_bad_queue
        $error("queue depth must be a power of two, width at least one");
    end

    // -------------------------------------------------------------
    // response queue
    // -------------------------------------------------------------
    logic [AW:0]   wr_ptr_r;
    logic [AW:0]   rd_ptr_r;
    logic          q_empty;
    logic          q_full;
    logic          q_push;
    logic          q_pop;
    logic          q_overflow;
    logic          q_underflow;
    logic [AW:0]   wr_ptr_nxt;
    logic [AW:0]   rd_ptr_nxt;

    // pointer compare with one wrap bit
    assign q_empty     = (wr_ptr_r == rd_ptr_r);
    assign q_full      = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
                         (wr_ptr_r[AW] != rd_ptr_r[AW]);
    assign q_push      = i_resp_valid && !q_full;
    // a push and a pop in one cycle both proceed, except the push when full and the pop when empty
    assign q_pop       = i_resp_read && !q_empty;
    // a full queue drops the new response; that counts as lost data
    assign q_overflow  = i_resp_valid && q_full;
    assign q_underflow = i_resp_read && q_empty;
    assign wr_ptr_nxt  = wr_ptr_r + (AW+1)'(1);
    assign rd_ptr_nxt  = rd_ptr_r + (AW+1)'(1);

    // queue pointers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (q_push) begin
                wr_ptr_r <= wr_ptr_nxt;
            end
            if (q_pop) begin
                rd_ptr_r <= rd_ptr_nxt;
            end
        end
    end

    resp_queue_mem #(
        .WIDTH (QWIDTH),
        .DEPTH (QDEPTH),
        .AW    (AW)
    ) u_mem (
        .i_clk   (i_clk),
        .i_we    (q_push),
        .i_waddr (wr_ptr_r[AW-1:0]),
        .i_wdata (i_resp_data),
        .i_re    (q_pop),
        .i_raddr (rd_ptr_r[AW-1:0]),
        .o_rdata (o_resp_data)
    );

    // read data valid one cycle after an accepted read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_resp_valid <= 1'b0;
        end else begin
            o_resp_valid <= q_pop;
        end
    end

    // -------------------------------------------------------------
    // standard event register
    // -------------------------------------------------------------
    logic [7:0] cond_now;
    logic [7:0] cond_prev_r;
    logic [7:0] cond_rise;
    logic [7:0] sev_r;
    logic [7:0] sev_nxt;
    logic [7:0] event_enable_r;

    // completion only after opc and nothing pending
    assign cond_now[SEV_OP_COMPLETE] = i_complete_cmd && !i_ops_pending;
    // unused event positions always read as zero
    assign cond_now[1]               = 1'b0;
    assign cond_now[SEV_QUERY_ERR]   = q_underflow || q_overflow || i_resp_lost;
    assign cond_now[SEV_DEVICE_ERR]  = i_memory_lost || i_selftest_fail;
    assign cond_now[SEV_EXEC_ERR]    = i_param_error || i_exec_blocked;
    // syntax or trigger inside a message
    assign cond_now[SEV_COMMAND_ERR] = i_syntax_error || i_trigger_in_msg;
    assign cond_now[7:6]             = 2'b00;

    // a held fault counts once; it must fall before it counts again
    // fixed rising-edge filter
    assign cond_rise = cond_now & ~cond_prev_r;

    // read clears, but a new rise in that cycle survives
    assign sev_nxt = ((i_event_read || i_clear_status) ? 8'h00 : sev_r) | cond_rise;

    // event latch and previous condition
    // previous conditions start low, so a level high at reset counts as a rise
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cond_prev_r <= 8'h00;
            sev_r       <= SEV_RESET;
        end else begin
            cond_prev_r <= cond_now;
            sev_r       <= sev_nxt;
        end
    end

    // -------------------------------------------------------------
    // enable masks
    // -------------------------------------------------------------
    logic [7:0] srq_enable_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            event_enable_r <= ENABLE_RESET;
            srq_enable_r   <= ENABLE_RESET;
        end else begin
            if (i_event_enable_we) begin
                event_enable_r <= i_event_enable_data;
            end
            if (i_srq_enable_we) begin
                srq_enable_r <= i_srq_enable_data;
            end
        end
    end

    // -------------------------------------------------------------
    // status byte
    // -------------------------------------------------------------
    logic [7:0] stb_sum;
    logic       master_sum;
    logic       master_prev_r;
    logic       svc_req_r;
    logic       svc_req_nxt;
    logic       svc_req_set;

    assign stb_sum[STB_CHANNEL_BIT] = i_channel_summary;
    assign stb_sum[STB_QUEST_BIT]   = i_questionable_summary;
    assign stb_sum[STB_MSG_AVAIL]   = !q_empty;
    assign stb_sum[STB_EVENT_SUM]   = |(sev_r & event_enable_r);
    assign stb_sum[STB_REQ_MASTER]  = 1'b0;
    assign stb_sum[7]               = 1'b0;
    assign stb_sum[1:0]             = 2'b00;

    // enabled bits, bit 6 mask ignored
    // masking bit 6 out keeps the request from feeding itself
    assign master_sum  = |(stb_sum & srq_enable_r & ~(8'h01 << STB_REQ_MASTER));
    assign svc_req_set = master_sum && !master_prev_r;
    // poll or clear drops request; a new rise wins
    assign svc_req_nxt = svc_req_set || (svc_req_r && !i_serial_poll && !i_clear_status);

    // request-service state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            master_prev_r <= 1'b0;
            svc_req_r     <= 1'b0;
        end else begin
            master_prev_r <= master_sum;
            svc_req_r     <= svc_req_nxt;
        end
    end

    // -------------------------------------------------------------
    // register answers
    // -------------------------------------------------------------
    logic [7:0] poll_byte;
    logic [7:0] query_byte;

    assign poll_byte  = stb_sum | ({7'h00, svc_req_r} << STB_REQ_MASTER);
    // query shows master summary, nothing cleared
    assign query_byte = stb_sum | ({7'h00, master_sum} << STB_REQ_MASTER);

    // answers registered one cycle after the request
    // limitation: one answer port, so a poll and a query together answer the poll
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_event_data       <= 8'h00;
            o_event_data_valid <= 1'b0;
            o_stb_data         <= 8'h00;
            o_stb_data_valid   <= 1'b0;
        end else begin
            o_event_data_valid <= i_event_read;
            o_stb_data_valid   <= i_serial_poll || i_stb_query;
            if (i_event_read) begin
                o_event_data <= sev_r;
            end
            if (i_serial_poll) begin
                o_stb_data <= poll_byte;
            end else if (i_stb_query) begin
                o_stb_data <= query_byte;
            end
        end
    end

    // mask readback and service request line
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_event_enable    <= ENABLE_RESET;
            o_srq_enable      <= ENABLE_RESET;
            o_service_request <= 1'b0;
        end else begin
            o_event_enable    <= event_enable_r;
            o_srq_enable      <= srq_enable_r;
            // next value used so the line rises with the request bit
            // line follows pending request
            o_service_request <= svc_req_nxt;
        end
    end
endmodule : status_reporting_summary
`default_nettype wire

// [verif/status_reporting_summary_monitor.sv]
// concurrent checks on the status reporting ports
`timescale 1ns/1ps
`default_nettype none
module status_reporting_summary_monitor (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst,
    // host side inputs
    input wire logic       i_resp_read,
    input wire logic       i_channel_summary,
    input wire logic       i_questionable_summary,
    input wire logic       i_srq_enable_we,
    input wire logic [7:0] i_srq_enable_data,
    input wire logic       i_event_read,
    input wire logic       i_serial_poll,
    input wire logic       i_stb_query,
    // answers
    input wire logic       o_resp_valid,
    input wire logic [7:0] o_event_data,
    input wire logic       o_event_data_valid,
    input wire logic [7:0] o_stb_data,
    input wire logic       o_stb_data_valid,
    input wire logic [7:0] o_srq_enable,
    input wire logic       o_service_request
);
    // ----------------------------------------------------------
    // one clock domain, checks idle in reset
    // ----------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_pop; o_resp_valid |-> $past(i_resp_read); endproperty
    a_pop: assert property (p_pop) else $error("word out without pop");
    property p_evrd; i_event_read |=> o_event_data_valid && o_event_data[7:6] == 2'b00
        && !o_event_data[1]; endproperty
    a_evrd: assert property (p_evrd) else $error("bad event answer");
    // summaries only compared while steady, the source may be sampled late
    property p_sum; (i_serial_poll || i_stb_query) && $stable(i_channel_summary)
        && $stable(i_questionable_summary) |=> o_stb_data_valid
        && o_stb_data[3:2] == $past({i_questionable_summary, i_channel_summary}); endproperty
    a_sum: assert property (p_sum) else $error("summary bits wrong");
    property p_zero; o_stb_data_valid |-> !o_stb_data[7] && o_stb_data[1:0] == 2'b00; endproperty
    a_zero: assert property (p_zero) else $error("unused status bits set");
    property p_poll; i_serial_poll |=> o_stb_data[6] == $past(o_service_request); endproperty
    a_poll: assert property (p_poll) else $error("poll bit 6 wrong");
    property p_master; i_stb_query && !i_serial_poll && !i_srq_enable_we
        |=> o_stb_data[6] == |(o_stb_data[5:2] & o_srq_enable[5:2]); endproperty
    a_master: assert property (p_master) else $error("master summary wrong");
    property p_rise; $rose(o_service_request) |-> |(o_srq_enable[5:2]); endproperty
    a_rise: assert property (p_rise) else $error("request without mask");
    // mask register takes the write, readback register follows one edge later
    property p_sre; i_srq_enable_we
        |-> ##2 o_srq_enable == $past(i_srq_enable_data, 2); endproperty
    a_sre: assert property (p_sre) else $error("mask readback wrong");
endmodule : status_reporting_summary_monitor
bind status_reporting_summary status_reporting_summary_monitor i_monitor (
    .i_clk, .i_rst, .i_resp_read, .i_channel_summary, .i_questionable_summary,
    .i_srq_enable_we, .i_srq_enable_data, .i_event_read, .i_serial_poll, .i_stb_query,
    .o_resp_valid, .o_event_data, .o_event_data_valid, .o_stb_data, .o_stb_data_valid,
    .o_srq_enable, .o_service_request);
`default_nettype wire

// [verif/host_model.sv]
// host controller model issuing status commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock and answers
    input  wire logic       i_clk,
    input  wire logic [7:0] i_event_data,
    input  wire logic [7:0] i_stb_data,
    input  wire logic [7:0] i_resp_data,
    // command strobes and mask value
    output logic      [6:0] o_cmd,
    output logic      [7:0] o_mask_data
);
    // ----------------------------------------------------------
    // one strobe at a time, answer taken a cycle later
    // ----------------------------------------------------------
    initial o_cmd = 7'h00;
    initial o_mask_data = 8'h00;
    task automatic issue(input int k, input logic [7:0] v, output logic [7:0] r);
        @(posedge i_clk);
        o_cmd       <= 7'(1 << k);
        o_mask_data <= v;
        @(posedge i_clk);
        o_cmd       <= 7'h00;
        o_mask_data <= ~v; // stale data must not pass for a write
        #1;
        r = (k == 2) ? i_event_data : (k == 6) ? i_resp_data : i_stb_data;
    endtask : issue
endmodule : host_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------------------------------------------
    // stimulus and answers
    // ----------------------------------------------------------
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       resp_valid = 1'b0;
    logic [7:0] resp_data = 8'h00;
    logic [6:0] cond = 7'h00; // lost, memory, selftest, param, blocked, syntax, trigger
    logic       complete_cmd = 1'b0;
    logic       ops_pending = 1'b0;
    logic [1:0] sums = 2'b00;
    logic [6:0] cmd;
    logic [7:0] mask_data, event_data, stb_data, resp_q, ev_en, srq_en, r;
    logic       resp_ok, srq;
    int         miscompares = 0;
    int         checked = 0;
    always #10 i_clk = ~i_clk;

    status_reporting_summary i_status_reporting_summary (
        .i_clk, .i_rst, .i_resp_valid(resp_valid), .i_resp_data(resp_data),
        .i_resp_lost(cond[0]), .i_resp_read(cmd[6]), .o_resp_valid(resp_ok),
        .o_resp_data(resp_q), .i_complete_cmd(complete_cmd), .i_ops_pending(ops_pending),
        .i_memory_lost(cond[1]), .i_selftest_fail(cond[2]), .i_param_error(cond[3]),
        .i_exec_blocked(cond[4]), .i_syntax_error(cond[5]), .i_trigger_in_msg(cond[6]),
        .i_channel_summary(sums[0]), .i_questionable_summary(sums[1]),
        .i_event_enable_we(cmd[4]), .i_event_enable_data(mask_data),
        .i_srq_enable_we(cmd[5]), .i_srq_enable_data(mask_data), .i_event_read(cmd[2]),
        .i_serial_poll(cmd[0]), .i_stb_query(cmd[1]), .i_clear_status(cmd[3]),
        .o_event_data(event_data), .o_event_data_valid(), .o_stb_data(stb_data),
        .o_stb_data_valid(), .o_event_enable(ev_en), .o_srq_enable(srq_en),
        .o_service_request(srq));
    host_model i_host_model (.i_clk, .i_event_data(event_data), .i_stb_data(stb_data),
        .i_resp_data(resp_q), .o_cmd(cmd), .o_mask_data(mask_data));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic host(input int k, input logic [7:0] v);
        i_host_model.issue(k, v, r);
    endtask : host
    // back-to-back pushes, ordered pops, then a pop on empty
    task automatic t_queue;
        for (int i = 0; i < 3; i++) begin
            @(posedge i_clk);
            resp_valid <= 1'b1;
            resp_data  <= 8'ha0 + 8'(i);
        end
        @(posedge i_clk) resp_valid <= 1'b0;
        host(1, 8'h00);
        chk(r, 8'h10);
        for (int i = 0; i < 3; i++) begin
            host(6, 8'h00);
            chk(r, 8'ha0 + 8'(i));
            chk(8'(resp_ok), 8'h01);
        end
        host(1, 8'h00);
        chk(r, 8'h00);
        host(6, 8'h00);
        chk(8'(resp_ok), 8'h00);
        host(2, 8'h00);
        chk(r, 8'h04);
    endtask : t_queue
    // one word past full is dropped and reported as lost data
    task automatic t_full;
        for (int i = 0; i <= status_pkg::QUEUE_DEPTH_DEF; i++) begin
            @(posedge i_clk);
            resp_valid <= 1'b1;
            resp_data  <= 8'(i);
        end
        @(posedge i_clk) resp_valid <= 1'b0;
        host(2, 8'h00);
        chk(r, 8'h04);
        for (int i = 0; i < status_pkg::QUEUE_DEPTH_DEF; i++) begin
            host(6, 8'h00);
            chk(r, 8'(i));
        end
        host(1, 8'h00);
        chk(r, 8'h00);
    endtask : t_full
    // each error source, read twice while still held high
    task automatic t_events;
        logic [7:0] exp [7] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h20, 8'h20};
        for (int i = 0; i < 7; i++) begin
            @(posedge i_clk) cond <= 7'(1 << i);
            host(2, 8'h00);
            chk(r, exp[i]);
            host(2, 8'h00);
            chk(r, 8'h00);
            @(posedge i_clk) cond <= 7'h00;
        end
        @(posedge i_clk) {complete_cmd, ops_pending} <= 2'b11;
        host(2, 8'h00);
        chk(r, 8'h00);
        @(posedge i_clk) ops_pending <= 1'b0;
        host(2, 8'h00);
        chk(r, 8'h01);
        @(posedge i_clk) complete_cmd <= 1'b0;
    endtask : t_events
    // masked summary, request, poll, query and clear
    task automatic t_service;
        host(4, 8'h10);
        host(5, 8'h20);
        chk(ev_en, 8'h10);
        // readback register trails the mask by one edge
        @(posedge i_clk);
        #1;
        chk(srq_en, 8'h20);
        @(posedge i_clk) {sums, cond} <= {2'b11, 7'h20};
        host(1, 8'h00);
        chk(r, 8'h0c);
        chk(8'(srq), 8'h00);
        @(posedge i_clk) cond <= 7'h28;
        repeat (4) @(posedge i_clk);
        #1;
        chk(8'(srq), 8'h01);
        host(1, 8'h00);
        chk(r, 8'h6c);
        host(0, 8'h00);
        chk(r, 8'h6c);
        chk(8'(srq), 8'h00);
        host(0, 8'h00);
        chk(r, 8'h2c);
        host(1, 8'h00);
        chk(r, 8'h6c);
        host(3, 8'h00);
        host(1, 8'h00);
        chk(r, 8'h0c);
        @(posedge i_clk) {sums, cond} <= 9'h000;
    endtask : t_service
    task automatic stop_test;
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // main sequence after four cycles of reset
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_queue();
        t_full();
        t_events();
        t_service();
        stop_test();
    end
    // watchdog, the tests need about 150 cycles
    initial begin
        #100us;
        miscompares++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
